// ### prog_port_consts.vh
// Constants for the memory programming port
`ifndef PROG_PORT_CONSTS_VH
`define PROG_PORT_CONSTS_VH
`define CMD_ERASE 8'h80
`define CMD_FUSE_WR 8'h40
`define CMD_LOCK_WR 8'h20
`define CMD_FLASH_WR 8'h10
`define CMD_EE_WR 8'h11
`define CMD_SIG_RD 8'h08
`define CMD_FL_RD 8'h04
`define CMD_FLASH_RD 8'h02
`define CMD_EE_RD 8'h03
`define ACT_ADDR 2'h0
`define ACT_DATA 2'h1
`define ACT_CMD 2'h2
`define SER_PREFIX 8'hAC
`define SER_ENABLE 8'h53
`define SER_FL_RD 8'h20
`define SER_FL_WR 8'h40
`define SER_EE_RD 8'hA0
`define SER_EE_WR 8'hC0
`define SER_SIG_RD 8'h30
`define POLL_VALUE 8'h7F
`define ERASED_BYTE 8'hFF
`define CLK_MHZ 20
`define WRITE_TIME_US 700
`define WRITE_CYCLES (`WRITE_TIME_US * `CLK_MHZ)
`define ERASE_TIME_US 10000
`define ERASE_CYCLES (`ERASE_TIME_US * `CLK_MHZ)
`define FUSE_SERIAL_PROGRAM_ENABLE_FUSE 5
`define FUSE_START 0
`define LOCK_TWO_IN 2
`define LOCK_ONE_IN 1
`define LOCK_ONE_OUT 7
`define LOCK_TWO_OUT 6
`define SIG_BYTE0 8'h5A
`define SIG_BYTE1 8'hA5
`define SIG_BYTE2 8'h3C
`endif

// ### edge_sync.v
// Two-stage synchroniser with edge detection
`timescale 1ns/10ps
module edge_sync (
    input wire clk,
    input wire resetn,
    input wire din,
    output reg level,
    output wire rise,
    output wire fall
);
    reg meta_q;
    always @(posedge clk) begin
        if (!resetn) begin
            meta_q <= 1'b0;
            level <= 1'b0;
        end else begin
            meta_q <= din;
            level <= meta_q;
        end
    end
    reg last_q;
    always @(posedge clk) begin
        if (!resetn) begin
            last_q <= 1'b0;
        end else begin
            last_q <= level;
        end
    end
    assign rise = level & ~last_q;
    assign fall = ~level & last_q;
endmodule // edge_sync

// ### serial_shifter.v
// Serial instruction shifter, four bytes MSB first
`timescale 1ns/10ps
module serial_shifter (
    input wire clk,
    input wire resetn,
    input wire active,
    input wire sckRise,
    input wire sckFall,
    input wire mosi,
    input wire [7:0] loadByte,
    output reg [31:0] instr,
    output reg [4:0] bitCount,
    output reg done,
    output reg miso
);
    reg [7:0] outShift_q;
    always @(posedge clk) begin
        if (!resetn || !active) begin
            instr <= 32'h0;
            bitCount <= 5'h0;
            done <= 1'b0;
            miso <= 1'b0;
            outShift_q <= 8'h0;
        end else begin
            done <= 1'b0;
            if (sckRise) begin
                instr <= {instr[30:0], mosi};
                bitCount <= bitCount + 5'h1;
                done <= (bitCount == 5'h1F);
            end
            if (sckFall) begin
                if (bitCount[2:0] == 3'h0) begin
                    miso <= loadByte[7];
                    outShift_q <= {loadByte[6:0], 1'b0};
                end else begin
                    miso <= outShift_q[7];
                    outShift_q <= {outShift_q[6:0], 1'b0};
                end
            end
        end
    end
endmodule // serial_shifter

// ### memory_programming_port.v
// Programming port for flash, EEPROM, fuses and locks
`timescale 1ns/10ps
`include "prog_port_consts.vh"
module memory_programming_port (
    input wire core_clk,
    input wire resetn,
    input wire parallelMode,
    input wire serialMode,
    input wire crystal_clock_input,
    input wire action_select_hi,
    input wire action_select_lo,
    input wire byte_select,
    input wire writeStrobeN,
    input wire outputEnableN,
    input wire [7:0] parallelDataIn,
    output reg [7:0] parallel_data_bus,
    output reg parallelDataOe,
    output reg ready_busy,
    input wire sck,
    input wire mosi,
    output reg miso,
    output reg programEnabled,
    output reg serial_program_enable_fuse,
    output reg startup_time_fuse,
    output reg lock_bit_one,
    output reg lock_bit_two
);
    parameter WRITE_CYCLES = `WRITE_CYCLES;
    parameter ERASE_CYCLES = `ERASE_CYCLES;
    localparam ST_IDLE = 2'h0;
    localparam ST_WRITE = 2'h1;
    localparam ST_ERASE = 2'h2;

    reg [7:0] flashLo [0:2047];
    reg [7:0] flashHi [0:2047];
    reg [7:0] eeMem [0:255];

    function [7:0] sigByte;
        input [1:0] a;
        begin
            if (a == 2'h0) sigByte = `SIG_BYTE0;
            else if (a == 2'h1) sigByte = `SIG_BYTE1;
            else if (a == 2'h2) sigByte = `SIG_BYTE2;
            else sigByte = 8'h00;
        end
    endfunction

    // Synchronise all input pins except core_clk and resetn
    wire xtalRise, wrFall, sckRise, sckFall;
    wire xa1, xa0, bsS, oeNS, mosiS, parS, serS, wrLevel;
    wire [7:0] pdS;
    edge_sync syncXtal (.clk(core_clk), .resetn(resetn), .din(crystal_clock_input),
        .level(), .rise(xtalRise), .fall());
    edge_sync syncWr (.clk(core_clk), .resetn(resetn), .din(writeStrobeN),
        .level(wrLevel), .rise(), .fall(wrFall));
    edge_sync syncSck (.clk(core_clk), .resetn(resetn), .din(sck),
        .level(), .rise(sckRise), .fall(sckFall));
    edge_sync syncXa1 (.clk(core_clk), .resetn(resetn), .din(action_select_hi),
        .level(xa1), .rise(), .fall());
    edge_sync syncXa0 (.clk(core_clk), .resetn(resetn), .din(action_select_lo),
        .level(xa0), .rise(), .fall());
    edge_sync syncBs (.clk(core_clk), .resetn(resetn), .din(byte_select),
        .level(bsS), .rise(), .fall());
    edge_sync syncOe (.clk(core_clk), .resetn(resetn), .din(~outputEnableN),
        .level(oeNS), .rise(), .fall());
    edge_sync syncMosi (.clk(core_clk), .resetn(resetn), .din(mosi),
        .level(mosiS), .rise(), .fall());
    edge_sync syncPar (.clk(core_clk), .resetn(resetn), .din(parallelMode),
        .level(parS), .rise(), .fall());
    edge_sync syncSer (.clk(core_clk), .resetn(resetn), .din(serialMode),
        .level(serS), .rise(), .fall());
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pd
            edge_sync syncPd (.clk(core_clk), .resetn(resetn), .din(parallelDataIn[gi]),
                .level(pdS[gi]), .rise(), .fall());
        end
    endgenerate
    wire oeActive = oeNS;

    // Parallel registers kept across operations
    reg [7:0] cmd_q;
    reg [10:0] addr_q;
    reg [7:0] data_q;
    reg [1:0] state_q;
    reg [23:0] timer_q;
    reg pendHi_q, pendEe_q, pendFuse_q, pendLock_q, eraseLock_q;
    reg [10:0] pendAddr_q;
    reg [7:0] pendData_q;
    reg busyPoll_q;

    // Serial side
    wire [31:0] instr;
    wire [4:0] bitCount;
    wire serDone, serMiso;
    reg [7:0] serOut;
    serial_shifter shifter (.clk(core_clk), .resetn(resetn), .active(serS),
        .sckRise(sckRise), .sckFall(sckFall), .mosi(mosiS), .loadByte(serOut),
        .instr(instr), .bitCount(bitCount), .done(serDone), .miso(serMiso));

    // Read data for serial byte four, and echo of byte two during byte three
    // Bytes two and three sit in the low half after 24 bits
    wire [10:0] serAddr = {instr[10:8], instr[7:0]};
    always @* begin
        serOut = 8'h00;
        if (bitCount == 5'h10 && instr[15:8] == `SER_PREFIX) begin
            serOut = instr[7:0];
        end else if (bitCount == 5'h18) begin
            if (instr[23:16] == `SER_FL_RD) begin
                serOut = (busyPoll_q && !pendEe_q && pendAddr_q == serAddr && !pendHi_q)
                    ? `POLL_VALUE : flashLo[serAddr];
            end else if (instr[23:16] == (`SER_FL_RD | 8'h08)) begin
                serOut = (busyPoll_q && !pendEe_q && pendAddr_q == serAddr && pendHi_q)
                    ? `POLL_VALUE : flashHi[serAddr];
            end else if (instr[23:16] == `SER_EE_RD) begin
                serOut = (busyPoll_q && pendEe_q && pendAddr_q[7:0] == instr[7:0])
                    ? `POLL_VALUE : eeMem[instr[7:0]];
            end else if (instr[23:16] == `SER_SIG_RD) begin
                serOut = sigByte(instr[1:0]);
            end
        end
    end

    // Parallel read path
    reg [7:0] parOut;
    always @* begin
        parOut = 8'h00;
        if (cmd_q == `CMD_FLASH_RD) begin
            parOut = bsS ? flashHi[addr_q] : flashLo[addr_q];
            if (busyPoll_q && !pendEe_q && pendAddr_q == addr_q && pendHi_q == bsS) begin
                parOut = `POLL_VALUE;
            end
        end else if (cmd_q == `CMD_EE_RD && !bsS) begin
            parOut = (busyPoll_q && pendEe_q && pendAddr_q[7:0] == addr_q[7:0])
                ? `POLL_VALUE : eeMem[addr_q[7:0]];
        end else if (cmd_q == `CMD_FL_RD && bsS) begin
            parOut = {lock_bit_one, lock_bit_two, serial_program_enable_fuse,
                4'hF, startup_time_fuse};
        end else if (cmd_q == `CMD_SIG_RD && !bsS) begin
            parOut = sigByte(addr_q[1:0]);
        end
    end

    integer k;
    always @(posedge core_clk) begin
        if (!resetn) begin
            cmd_q <= 8'h00;
            addr_q <= 11'h000;
            data_q <= 8'h00;
            state_q <= ST_IDLE;
            timer_q <= 24'h0;
            pendHi_q <= 1'b0;
            pendEe_q <= 1'b0;
            pendFuse_q <= 1'b0;
            pendLock_q <= 1'b0;
            eraseLock_q <= 1'b0;
            pendAddr_q <= 11'h000;
            pendData_q <= 8'h00;
            busyPoll_q <= 1'b0;
            ready_busy <= 1'b1;
            parallel_data_bus <= 8'h00;
            parallelDataOe <= 1'b0;
            miso <= 1'b0;
            programEnabled <= 1'b0;
            serial_program_enable_fuse <= 1'b0;
            startup_time_fuse <= 1'b1;
            lock_bit_one <= 1'b1;
            lock_bit_two <= 1'b1;
        end else begin
            parallelDataOe <= parS && oeActive;
            parallel_data_bus <= parOut;
            miso <= serMiso;
            if (!serS) begin
                programEnabled <= 1'b0;
            end
            // Crystal pulse loads address, data or command
            if (parS && xtalRise) begin
                if ({xa1, xa0} == `ACT_ADDR) begin
                    if (bsS) addr_q[10:8] <= pdS[2:0];
                    else addr_q[7:0] <= pdS;
                end else if ({xa1, xa0} == `ACT_DATA) begin
                    data_q <= pdS;
                end else if ({xa1, xa0} == `ACT_CMD) begin
                    cmd_q <= pdS;
                    if (pdS == `CMD_ERASE && state_q == ST_IDLE) begin
                        state_q <= ST_ERASE;
                        timer_q <= ERASE_CYCLES[23:0];
                        eraseLock_q <= 1'b0;
                    end
                end
            end
            case (state_q)
                ST_IDLE: begin
                    if (parS && wrFall) begin
                        pendAddr_q <= addr_q;
                        pendData_q <= data_q;
                        pendHi_q <= bsS;
                        pendEe_q <= (cmd_q == `CMD_EE_WR);
                        pendFuse_q <= (cmd_q == `CMD_FUSE_WR);
                        pendLock_q <= (cmd_q == `CMD_LOCK_WR);
                        if (cmd_q == `CMD_FLASH_WR || cmd_q == `CMD_EE_WR ||
                            cmd_q == `CMD_FUSE_WR || cmd_q == `CMD_LOCK_WR) begin
                            state_q <= ST_WRITE;
                            timer_q <= WRITE_CYCLES[23:0];
                            ready_busy <= 1'b0;
                            busyPoll_q <= 1'b1;
                        end
                    end else if (serS && serDone) begin
                        if (instr[31:24] == `SER_PREFIX && instr[23:16] == `SER_ENABLE) begin
                            programEnabled <= 1'b1;
                        end else if (programEnabled) begin
                            if (instr[31:24] == `SER_PREFIX && instr[23:21] == 3'h4) begin
                                state_q <= ST_ERASE;
                                timer_q <= ERASE_CYCLES[23:0];
                                eraseLock_q <= 1'b1;
                            end else if (instr[31:24] == `SER_PREFIX &&
                                instr[23:21] == 3'h7) begin
                                lock_bit_two <= lock_bit_two & instr[18];
                                lock_bit_one <= lock_bit_one & instr[17];
                            end else if (instr[31:24] == `SER_FL_WR ||
                                instr[31:24] == (`SER_FL_WR | 8'h08) ||
                                instr[31:24] == `SER_EE_WR) begin
                                pendAddr_q <= {instr[18:16], instr[15:8]};
                                pendData_q <= instr[7:0];
                                pendHi_q <= instr[27];
                                pendEe_q <= (instr[31:24] == `SER_EE_WR);
                                pendFuse_q <= 1'b0;
                                pendLock_q <= 1'b0;
                                state_q <= ST_WRITE;
                                timer_q <= WRITE_CYCLES[23:0];
                                busyPoll_q <= 1'b1;
                            end
                        end
                    end
                end
                ST_WRITE: begin
                    if (timer_q == 24'h1) begin
                        state_q <= ST_IDLE;
                        ready_busy <= 1'b1;
                        busyPoll_q <= 1'b0;
                        if (pendFuse_q) begin
                            serial_program_enable_fuse <= pendData_q[`FUSE_SERIAL_PROGRAM_ENABLE_FUSE];
                            startup_time_fuse <= pendData_q[`FUSE_START];
                        end else if (pendLock_q) begin
                            lock_bit_two <= lock_bit_two & pendData_q[`LOCK_TWO_IN];
                            lock_bit_one <= lock_bit_one & pendData_q[`LOCK_ONE_IN];
                        end else if (pendEe_q) begin
                            // Serial and parallel both overwrite whole byte
                            eeMem[pendAddr_q[7:0]] <= pendData_q;
                        end else if (pendHi_q) begin
                            flashHi[pendAddr_q] <= flashHi[pendAddr_q] & pendData_q;
                        end else begin
                            flashLo[pendAddr_q] <= flashLo[pendAddr_q] & pendData_q;
                        end
                    end else begin
                        timer_q <= timer_q - 24'h1;
                    end
                end
                ST_ERASE: begin
                    if (parS && wrFall) begin
                        eraseLock_q <= 1'b1;
                    end
                    if (timer_q == 24'h1) begin
                        state_q <= ST_IDLE;
                        for (k = 0; k < 2048; k = k + 1) begin
                            flashLo[k] <= `ERASED_BYTE;
                            flashHi[k] <= `ERASED_BYTE;
                        end
                        for (k = 0; k < 256; k = k + 1) begin
                            eeMem[k] <= `ERASED_BYTE;
                        end
                        if (eraseLock_q) begin
                            lock_bit_one <= 1'b1;
                            lock_bit_two <= 1'b1;
                        end
                    end else begin
                        timer_q <= timer_q - 24'h1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
    wire unusedWr = wrLevel;
endmodule // memory_programming_port

// ### memory_programming_port_properties.sv
// Checker for the memory programming port pins
`timescale 1ns/10ps
module memory_programming_port_properties #(
    parameter WRITE_CYCLES = 400,
    parameter ERASE_CYCLES = 200
) (
    input wire core_clk,
    input wire resetn,
    input wire parallelMode,
    input wire serialMode,
    input wire writeStrobeN,
    input wire outputEnableN,
    input wire parallelDataOe,
    input wire ready_busy,
    input wire sck,
    input wire miso,
    input wire programEnabled,
    input wire serial_program_enable_fuse,
    input wire startup_time_fuse,
    input wire lock_bit_one,
    input wire lock_bit_two
);
    int busyCnt;
    int wrAge;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    // Busy length and age of the last strobe fall
    always @(posedge core_clk) begin
        if (!resetn) begin
            busyCnt <= 0;
            wrAge <= 100;
        end else begin
            busyCnt <= ready_busy ? 0 : busyCnt + 1;
            wrAge <= $fell(writeStrobeN) ? 0 : (wrAge < 100 ? wrAge + 1 : wrAge);
        end
    end
    a_busy_cause: assert property ($fell(ready_busy) && parallelMode |-> wrAge <= 8)
        else $error("busy without a write strobe");
    a_busy_length: assert property ($rose(ready_busy) && parallelMode |->
        busyCnt >= WRITE_CYCLES - 2 && busyCnt <= WRITE_CYCLES + 3)
        else $error("busy length wrong");
    a_busy_bounded: assert property (!ready_busy && parallelMode |->
        busyCnt <= WRITE_CYCLES + 3)
        else $error("busy too long");
    a_oe_idle: assert property (outputEnableN [*6] |-> !parallelDataOe)
        else $error("bus driven with output enable high");
    a_oe_drive: assert property ((parallelMode && !outputEnableN) [*6] |-> parallelDataOe)
        else $error("bus not driven with output enable low");
    a_enable_mode: assert property ($rose(programEnabled) |-> serialMode)
        else $error("enabled outside serial mode");
    a_enable_drop: assert property (!serialMode [*6] |-> !programEnabled)
        else $error("enable kept outside serial mode");
    a_lock_mode: assert property ($rose(lock_bit_one) || $rose(lock_bit_two) |->
        parallelMode || serialMode)
        else $error("lock cleared outside programming");
    a_fuse_idle: assert property ((!parallelMode && !serialMode) [*4] |=>
        $stable({serial_program_enable_fuse, startup_time_fuse}))
        else $error("fuse changed outside programming");
    a_miso_edge: assert property ($rose(sck) && serialMode |=> $stable(miso) [*3])
        else $error("serial output changed after rising clock");
endmodule // memory_programming_port_properties
bind memory_programming_port memory_programming_port_properties #(
    .WRITE_CYCLES(WRITE_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) chk_u (
    .core_clk, .resetn, .parallelMode, .serialMode, .writeStrobeN, .outputEnableN,
    .parallelDataOe, .ready_busy, .sck, .miso, .programEnabled, .serial_program_enable_fuse,
    .startup_time_fuse, .lock_bit_one, .lock_bit_two);

// ### programmer_model.sv
// Behavioural external programmer on the serial pins
`timescale 1ns/10ps
module programmer_model (
    output logic sck,
    output logic mosi,
    input wire miso
);
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
    end
    // One four-byte instruction, clock idle low between frames
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        int i;
        #13;
        for (i = 31; i >= 0; i--) begin
            mosi = tx[i];
            #200 sck = 1'b1;
            rx[i] = miso;
            #200 sck = 1'b0;
        end
        mosi = ~mosi;
    endtask
endmodule // programmer_model

// ### memory_programming_port_tb.sv
// Self-checking bench for the memory programming port
`timescale 1ns/10ps
`include "prog_port_consts.vh"
module memory_programming_port_tb;
    localparam int WC = 400;
    localparam int EC = 200;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic parallelMode = 1'b0;
    logic serialMode = 1'b0;
    logic crystal_clock_input = 1'b0;
    logic action_select_hi = 1'b1;
    logic action_select_lo = 1'b1;
    logic byte_select = 1'b0;
    logic writeStrobeN = 1'b1;
    logic outputEnableN = 1'b1;
    logic [7:0] parallelDataIn = 8'h00;
    logic [7:0] parallel_data_bus;
    logic parallelDataOe, ready_busy, sck, mosi, miso, programEnabled;
    logic serial_program_enable_fuse, startup_time_fuse, lock_bit_one, lock_bit_two;
    logic [31:0] rx;
    logic [7:0] sig [3] = '{`SIG_BYTE0, `SIG_BYTE1, `SIG_BYTE2};
    int fails = 0;
    int comparisons = 0;
    int n;
    memory_programming_port #(.WRITE_CYCLES(WC), .ERASE_CYCLES(EC)) dut_u (
        .core_clk, .resetn, .parallelMode, .serialMode, .crystal_clock_input,
        .action_select_hi, .action_select_lo, .byte_select, .writeStrobeN, .outputEnableN,
        .parallelDataIn, .parallel_data_bus, .parallelDataOe, .ready_busy, .sck, .mosi,
        .miso, .programEnabled, .serial_program_enable_fuse, .startup_time_fuse,
        .lock_bit_one, .lock_bit_two);
    programmer_model prog_u (.sck, .mosi, .miso);
    always #25 core_clk = ~core_clk;
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task cyc(input int c);
        repeat (c) @(negedge core_clk);
    endtask
    task xp(input logic [1:0] a, input logic bs, input logic [7:0] d);
        {action_select_hi, action_select_lo} = a;
        byte_select = bs;
        parallelDataIn = d;
        cyc(2);
        crystal_clock_input = 1'b1;
        cyc(4);
        crystal_clock_input = 1'b0;
        cyc(4);
    endtask
    task strobe;
        writeStrobeN = 1'b0;
        cyc(4);
        writeStrobeN = 1'b1;
    endtask
    task wr(input logic bs);
        byte_select = bs;
        cyc(2);
        strobe();
        for (n = 0; ready_busy !== 1'b0 && n < 10; n++) cyc(1);
        chk("busy", 8'h00, {7'h00, ready_busy});
        for (n = 0; ready_busy !== 1'b1 && n < WC + 20; n++) cyc(1);
        chk("ready", 8'h01, {7'h00, ready_busy});
    endtask
    task rd(input logic bs, input logic [7:0] exp, input string name);
        byte_select = bs;
        cyc(2);
        outputEnableN = 1'b0;
        cyc(8);
        chk(name, exp, parallel_data_bus);
        chk("drive", 8'h01, {7'h00, parallelDataOe});
        outputEnableN = 1'b1;
        cyc(8);
    endtask
    task erase;
        xp(2'h2, 1'b0, `CMD_ERASE);
        strobe();
        cyc(EC + 50);
        chk("erase ready", 8'h01, {7'h00, ready_busy});
    endtask
    task ser(input logic [31:0] tx);
        prog_u.xfer(tx, rx);
        cyc(4);
    endtask
    task print_verdict;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #2000000;
        fails++;
        print_verdict();
    end
    initial begin
        cyc(6);
        resetn = 1'b1;
        cyc(6);
        chk("ready", 8'h01, {7'h00, ready_busy});
        chk("fuses", 8'h07, {4'h0, serial_program_enable_fuse, startup_time_fuse,
            lock_bit_one, lock_bit_two});
        $display("test reset done");
        parallelMode = 1'b1;
        cyc(6);
        erase();
        xp(2'h2, 1'b0, `CMD_FLASH_WR);
        xp(2'h0, 1'b0, 8'h05);
        xp(2'h0, 1'b1, 8'h01);
        xp(2'h1, 1'b0, 8'hA5);
        wr(1'b0);
        xp(2'h1, 1'b0, 8'h3C);
        wr(1'b1);
        xp(2'h2, 1'b0, `CMD_FLASH_RD);
        rd(1'b0, 8'hA5, "flash low");
        rd(1'b1, 8'h3C, "flash high");
        xp(2'h2, 1'b0, `CMD_EE_WR);
        xp(2'h0, 1'b0, 8'h10);
        xp(2'h1, 1'b0, 8'h5A);
        wr(1'b0);
        xp(2'h2, 1'b0, `CMD_EE_RD);
        rd(1'b0, 8'h5A, "eeprom");
        xp(2'h2, 1'b0, `CMD_FUSE_WR);
        xp(2'h1, 1'b0, 8'hDE);
        wr(1'b0);
        chk("fuse pins", 8'h00, {6'h00, serial_program_enable_fuse, startup_time_fuse});
        xp(2'h2, 1'b0, `CMD_FL_RD);
        rd(1'b1, 8'hDE, "fuse read");
        xp(2'h2, 1'b0, `CMD_LOCK_WR);
        xp(2'h1, 1'b0, 8'hFB);
        wr(1'b0);
        xp(2'h2, 1'b0, `CMD_FL_RD);
        rd(1'b1, 8'h9E, "lock read");
        xp(2'h2, 1'b0, `CMD_SIG_RD);
        for (int i = 0; i < 3; i++) begin
            xp(2'h0, 1'b0, i[7:0]);
            rd(1'b0, sig[i], "signature");
        end
        erase();
        chk("locks", 8'h03, {6'h00, lock_bit_one, lock_bit_two});
        $display("test parallel done");
        parallelMode = 1'b0;
        serialMode = 1'b1;
        cyc(10);
        ser({`SER_EE_WR, 24'h002077});
        cyc(WC + 50);
        chk("enabled", 8'h00, {7'h00, programEnabled});
        ser({`SER_PREFIX, `SER_ENABLE, 16'h0000});
        chk("echo", `SER_ENABLE, rx[15:8]);
        chk("enabled", 8'h01, {7'h00, programEnabled});
        ser({`SER_EE_RD, 24'h002000});
        chk("refused write", `ERASED_BYTE, rx[7:0]);
        ser({`SER_EE_WR, 24'h002077});
        ser({`SER_EE_RD, 24'h002000});
        chk("poll", `POLL_VALUE, rx[7:0]);
        cyc(WC);
        ser({`SER_EE_RD, 24'h002000});
        chk("eeprom", 8'h77, rx[7:0]);
        ser({`SER_EE_WR, 24'h002088});
        cyc(WC + 50);
        ser({`SER_EE_RD, 24'h002000});
        chk("auto erase", 8'h88, rx[7:0]);
        ser({`SER_FL_WR | 8'h08, 24'h010796});
        cyc(WC + 50);
        ser({`SER_FL_RD | 8'h08, 24'h010700});
        chk("flash high", 8'h96, rx[7:0]);
        ser({`SER_FL_RD, 24'h010700});
        chk("flash low", `ERASED_BYTE, rx[7:0]);
        ser({`SER_SIG_RD, 24'h000200});
        chk("signature", `SIG_BYTE2, rx[7:0]);
        ser({`SER_PREFIX, 24'hE40000});
        chk("serial lock", 8'h01, {6'h00, lock_bit_one, lock_bit_two});
        ser({`SER_PREFIX, 24'h800000});
        cyc(EC + 50);
        ser({`SER_EE_RD, 24'h002000});
        chk("erased", `ERASED_BYTE, rx[7:0]);
        $display("test serial done");
        print_verdict();
    end
endmodule // memory_programming_port_tb
